// ===== port_pin_and_irq_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppi_map.svh"

module port_pin_and_irq_control_test;
  logic clk = 1'b0, rstn = 1'b0, wrEn = 1'b0, cfgI = 1'b0, dirI = 1'b0, retI = 1'b0;
  logic slp = 1'b0, pbAcc = 1'b0, ext_irq_pin_select = 1'b0, tOvf = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, acc = 8'h00, opnd = 8'h00, wuc = 8'h00;
  logic [7:0] pdn = 8'hFF, latA = 8'h00, latB = 8'h00, extB = 8'h00, a, m;
  logic [7:0] rdOut, pinA, pinB, phEn, syncA, syncB;
  logic [3:0] pdEnA, pdEnB, pexp;
  logic irqV, wake;
  ppi_pkg::ppi_drive_t drvA, drvB;
  ppi_pkg::ppi_cfg_t cfg;
  int err_total = 0;
  int num_checks = 0;

  // core clock, 50 ns period
  always #25 clk = ~clk;

  ppi_port_irq_ctrl u_ppi_port_irq_ctrl (.clk(clk), .rstn(rstn), .fileAddr(addr),
    .fileWrEn(wrEn), .fileWrData(wdat), .fileRdData(rdOut), .workAccumulator(acc),
    .configInstr(cfgI), .directionLoadInstr(dirI), .directionOperand(opnd),
    .returnFromIrqInstr(retI), .sleepActive(slp), .portBAccess(pbAcc),
    .extIrqPinSelect(ext_irq_pin_select), .wakeupChangeCtrl(wuc), .pullDownCtrlN(pdn), .portALatch(latA),
    .portBLatch(latB), .timerOverflow(tOvf), .portAPinIn(pinA), .portBPinIn(pinB),
    .portADrive(drvA), .portBDrive(drvB), .portBPullHighEn(phEn), .portAPullDownEn(pdEnA),
    .portBPullDownEn(pdEnB), .portAPinSync(syncA), .portBPinSync(syncB), .timerCfg(cfg),
    .prescaleExp(pexp), .irqVector(irqV), .wakeResume(wake));

  ppi_pin_model u_ppi_pin_model (.clk(clk), .drvA(drvA), .drvB(drvB), .pullHighB(phEn),
    .pullDownA(pdEnA), .pullDownB(pdEnB), .extEnA(8'hFF), .extA(8'h3C), .extEnB(8'hFF),
    .extB(extB), .pinA(pinA), .pinB(pinB));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    tick(1);
    addr = ad;
    wdat = d;
    wrEn = 1'b1;
    tick(1);
    wrEn = 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] ad, input logic [7:0] exp);
    tick(1);
    addr = ad;
    tick(1);
    check(nm, rdOut, exp);
  endtask

  // one-cycle pulse: 0 config, 1 direction, 2 return, 3 overflow, 4 port access
  task automatic instr(input int k, input logic [7:0] ac, input logic [7:0] op);
    tick(1);
    acc = ac;
    opnd = op;
    case (k)
      0: cfgI = 1'b1;
      1: dirI = 1'b1;
      2: retI = 1'b1;
      3: tOvf = 1'b1;
      default: pbAcc = 1'b1;
    endcase
    tick(1);
    {cfgI, dirI, retI, tOvf, pbAcc} = 5'h00;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end

  initial begin
    tick(16);
    rstn = 1'b1;
    tick(1);
    check("config", {1'b0, cfg}, {1'b0, `PPI_RST_CONFIG});
    check("prescale", {4'h0, pexp}, 8'h07);
    check("a oe", drvA.oe, 8'h00);
    check("b oe", drvB.oe, 8'h00);
    rdc("open drain", `PPI_ADDR_OPEN_DRAIN, `PPI_RST_OPEN_DRAIN);
    rdc("pull high", `PPI_ADDR_PULL_HIGH, `PPI_RST_PULL_HIGH);
    rdc("enable", `PPI_ADDR_IRQ_ENABLE, `PPI_RST_IRQ_ENABLE);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, `PPI_RST_IRQ_FLAGS);
    rdc("unmapped", 8'h10, 8'h00);
    wr(`PPI_ADDR_IRQ_ENABLE, 8'hFF);
    rdc("enable", `PPI_ADDR_IRQ_ENABLE, 8'h87);
    wr(`PPI_ADDR_IRQ_ENABLE, 8'h00);
    $display("test reset and registers done");
    // every config bit both ways, ratio with either assignment
    for (int i = 0; i < 16; i++) begin
      a = {1'b1, i[0], i[1], ~i[1], i[3], i[2:0]};
      instr(0, a, 8'h00);
      tick(2);
      check("config", {1'b0, cfg}, {1'b0, a[6:0]});
      check("prescale", {4'h0, pexp}, {5'h00, a[2:0]} + {7'h00, ~a[3]});
    end
    $display("test config done");
    wr(`PPI_ADDR_IRQ_ENABLE, 8'h81);
    instr(3, 8'h00, 8'h00);
    for (int i = 0; i < 10 && irqV !== 1'b1; i++) tick(1);
    check("irq taken", {7'h00, irqV}, 8'h01);
    if (irqV !== 1'b1) complete_run();
    rdc("enable", `PPI_ADDR_IRQ_ENABLE, 8'h01);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h01);
    wr(`PPI_ADDR_IRQ_FLAGS, 8'h00);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h00);
    instr(2, 8'h00, 8'h00);
    rdc("enable", `PPI_ADDR_IRQ_ENABLE, 8'h81);
    wr(`PPI_ADDR_IRQ_ENABLE, 8'h00);
    $display("test timer irq done");
    instr(0, 8'h40, 8'h00);
    ext_irq_pin_select = 1'b1;
    wuc = 8'h01;
    wr(`PPI_ADDR_IRQ_ENABLE, 8'h06);
    instr(4, 8'h00, 8'h00);
    tick(10);
    extB = 8'h01;
    tick(10);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h04);
    slp = 1'b1;
    tick(2);
    check("wake resume", {7'h00, wake}, 8'h01);
    slp = 1'b0;
    wr(`PPI_ADDR_IRQ_FLAGS, 8'h00);
    extB = 8'h00;
    tick(10);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h00);
    wuc = 8'h02;
    instr(4, 8'h00, 8'h00);
    extB = 8'h02;
    tick(10);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h02);
    tick(5);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h02);
    instr(4, 8'h00, 8'h00);
    wr(`PPI_ADDR_IRQ_FLAGS, 8'h00);
    rdc("flags", `PPI_ADDR_IRQ_FLAGS, 8'h00);
    wr(`PPI_ADDR_IRQ_ENABLE, 8'h00);
    $display("test pin irq done");
    wr(`PPI_ADDR_OPEN_DRAIN, 8'hF0);
    wr(`PPI_ADDR_PULL_HIGH, 8'h00);
    pdn = 8'h00;
    latB = 8'h5A;
    latA = 8'hFF;
    instr(1, 8'h33, `PPI_DIR_OPERAND_B);
    instr(1, 8'h00, `PPI_DIR_OPERAND_A);
    tick(3);
    m = ~8'h33 & ~(8'hF0 & latB);
    check("b oe", drvB.oe, m);
    check("b out", drvB.out & m, latB & m);
    check("b pull high", phEn, 8'h33);
    check("b pull down", {4'h0, pdEnB}, 8'h03);
    check("a oe", drvA.oe, 8'hDF);
    check("a pull down", {4'h0, pdEnA}, 8'h00);
    check("a out", drvA.out, 8'hFF);
    check("a pin sync", syncA, 8'h3C);
    check("b pin sync", syncB, 8'h02);
    instr(1, 8'hFF, 8'h07);
    tick(3);
    check("b oe", drvB.oe, m);
    $display("test drive done");
    complete_run();
  end
endmodule // port_pin_and_irq_control_test

`default_nettype wire

// ===== ppi_map.svh
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH

// file addresses of the control registers
`define PPI_ADDR_OPEN_DRAIN  8'h0C
`define PPI_ADDR_PULL_HIGH   8'h0D
`define PPI_ADDR_IRQ_ENABLE  8'h0E
`define PPI_ADDR_IRQ_FLAGS   8'h0F

// direction-load operands
`define PPI_DIR_OPERAND_A    8'h05
`define PPI_DIR_OPERAND_B    8'h06

// irq enable / flag bit positions
`define PPI_BIT_TIMER        0
`define PPI_BIT_PORT_CHANGE  1
`define PPI_BIT_EXT_PIN      2
`define PPI_BIT_GLOBAL       7

// implemented-bit masks
`define PPI_MASK_IRQ_ENABLE  8'h87
`define PPI_MASK_IRQ_FLAGS   8'h07

// reset values
`define PPI_RST_OPEN_DRAIN   8'h00
`define PPI_RST_PULL_HIGH    8'hFF
`define PPI_RST_IRQ_ENABLE   8'h00
`define PPI_RST_IRQ_FLAGS    8'h00
`define PPI_RST_CONFIG       7'h3F
`define PPI_RST_DIRECTION    8'hFF

`endif

// ===== ppi_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// external circuitry on the sixteen port pins
module ppi_pin_model (
  input  wire logic                clk,
  input  wire ppi_pkg::ppi_drive_t drvA,
  input  wire ppi_pkg::ppi_drive_t drvB,
  input  wire logic [7:0]          pullHighB,
  input  wire logic [3:0]          pullDownA,
  input  wire logic [3:0]          pullDownB,
  input  wire logic [7:0]          extEnA,
  input  wire logic [7:0]          extA,
  input  wire logic [7:0]          extEnB,
  input  wire logic [7:0]          extB,
  output logic [7:0]               pinA,
  output logic [7:0]               pinB
);
  logic [7:0] lastA_reg;
  logic [7:0] lastB_reg;
  logic [7:0] pdA;
  logic [7:0] pdB;

  assign pdA = {4'h0, pullDownA};
  assign pdB = {4'h0, pullDownB};

  // outside driver first, then device driver, then pulls; a floating pin flips
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinA[i] = extEnA[i] ? extA[i] : drvA.oe[i] ? drvA.out[i] : pdA[i] ? 1'b0 : ~lastA_reg[i];
      pinB[i] = extEnB[i] ? extB[i] : drvB.oe[i] ? drvB.out[i] : pullHighB[i] ? 1'b1
              : pdB[i] ? 1'b0 : ~lastB_reg[i];
    end
  end

  // last level seen on each pin
  always_ff @(posedge clk) begin
    lastA_reg <= pinA;
    lastB_reg <= pinB;
  end
endmodule // ppi_pin_model

`default_nettype wire

// ===== ppi_pkg.sv
`default_nettype none

package ppi_pkg;

  // timer and interrupt configuration, bit 6 down to bit 0
  typedef struct packed {
    logic       extIrqEdgeSel;
    logic       timerClockSrcSel;
    logic       timerSrcEdgeSel;
    logic       prescalerAssign;
    logic [2:0] prescalerRatio;
  } ppi_cfg_t;

  // drive of one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ppi_drive_t;

endpackage

`default_nettype wire

// ===== ppi_port_irq_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppi_map.svh"

module ppi_port_irq_ctrl (
  input  wire logic            clk,
  input  wire logic            rstn,
  // core file-register access
  input  wire logic [7:0]      fileAddr,
  input  wire logic            fileWrEn,
  input  wire logic [7:0]      fileWrData,
  output logic [7:0]           fileRdData,
  // dedicated instructions
  input  wire logic [7:0]      workAccumulator,
  input  wire logic            configInstr,
  input  wire logic            directionLoadInstr,
  input  wire logic [7:0]      directionOperand,
  input  wire logic            returnFromIrqInstr,
  input  wire logic            sleepActive,
  input  wire logic            portBAccess,
  // neighbouring control registers and latches
  input  wire logic            extIrqPinSelect,
  input  wire logic [7:0]      wakeupChangeCtrl,
  input  wire logic [7:0]      pullDownCtrlN,
  input  wire logic [7:0]      portALatch,
  input  wire logic [7:0]      portBLatch,
  input  wire logic            timerOverflow,
  // pins
  input  wire logic [7:0]      portAPinIn,
  input  wire logic [7:0]      portBPinIn,
  output ppi_pkg::ppi_drive_t  portADrive,
  output ppi_pkg::ppi_drive_t  portBDrive,
  output logic [7:0]           portBPullHighEn,
  output logic [3:0]           portAPullDownEn,
  output logic [3:0]           portBPullDownEn,
  output logic [7:0]           portAPinSync,
  output logic [7:0]           portBPinSync,
  // to core and timer
  output ppi_pkg::ppi_cfg_t    timerCfg,
  output logic [3:0]           prescaleExp,
  output logic                 irqVector,
  output logic                 wakeResume
);

  // prescaler exponent: watchdog 2^n, timer 2^(n+1)
  function automatic logic [3:0] divExp(input logic toWdt, input logic [2:0] n);
    divExp = toWdt ? {1'b0, n} : ({1'b0, n} + 4'h1);
  endfunction

  logic [7:0]          openDrain_reg;
  logic [7:0]          pullHighN_reg;
  logic [7:0]          irqEnable_reg;
  logic [7:0]          irqFlags_reg;
  ppi_pkg::ppi_cfg_t   cfg_reg;
  logic [7:0]          dirA_reg;
  logic [7:0]          dirB_reg;
  logic [7:0]          syncA1_reg, syncA2_reg, syncA3_reg;
  logic [7:0]          syncB1_reg, syncB2_reg, syncB3_reg;
  logic [7:0]          stableA_reg, stableB_reg;
  logic [7:0]          portBRef_reg;
  logic                extLevel_reg;

  // address decode
  wire logic selOd  = fileAddr == `PPI_ADDR_OPEN_DRAIN;
  wire logic selPh  = fileAddr == `PPI_ADDR_PULL_HIGH;
  wire logic selEn  = fileAddr == `PPI_ADDR_IRQ_ENABLE;
  wire logic selFl  = fileAddr == `PPI_ADDR_IRQ_FLAGS;
  wire logic wrOd   = fileWrEn & selOd;
  wire logic wrPh   = fileWrEn & selPh;
  wire logic wrEn   = fileWrEn & selEn;
  wire logic wrFl   = fileWrEn & selFl;
  wire logic ldDirA = directionLoadInstr & (directionOperand == `PPI_DIR_OPERAND_A);
  wire logic ldDirB = directionLoadInstr & (directionOperand == `PPI_DIR_OPERAND_B);

  // debounced pin levels: second and third stage agree
  wire logic [7:0] stableA_next = (syncA2_reg & syncA3_reg) | (stableA_reg & (syncA2_reg ^ syncA3_reg));
  wire logic [7:0] stableB_next = (syncB2_reg & syncB3_reg) | (stableB_reg & (syncB2_reg ^ syncB3_reg));

  // port B change detection
  wire logic [7:0] changeMask = wakeupChangeCtrl & dirB_reg
                              & {7'h7F, ~extIrqPinSelect};
  wire logic       portChange = |((stableB_reg ^ portBRef_reg) & changeMask);

  // external pin edge on port B pin 0
  wire logic extRise = ~extLevel_reg & stableB_reg[0];
  wire logic extFall = extLevel_reg & ~stableB_reg[0];
  wire logic extEdge = extIrqPinSelect
                     & (cfg_reg.extIrqEdgeSel ? extRise : extFall);

  // flag set events, set wins over software clear
  wire logic [7:0] flagSet = {5'h00,
                              extEdge,
                              portChange & irqEnable_reg[`PPI_BIT_PORT_CHANGE],
                              timerOverflow};
  wire logic [7:0] flagBase = wrFl ? (fileWrData & `PPI_MASK_IRQ_FLAGS) : irqFlags_reg;
  wire logic [7:0] irqFlags_next = (flagBase | flagSet) & `PPI_MASK_IRQ_FLAGS;

  // interrupt acceptance
  wire logic pending = |(irqFlags_reg[2:0] & irqEnable_reg[2:0]);
  wire logic global_irq_enable     = irqEnable_reg[`PPI_BIT_GLOBAL];
  wire logic take    = global_irq_enable & pending;
  wire logic [7:0] enBase = wrEn ? (fileWrData & `PPI_MASK_IRQ_ENABLE) : irqEnable_reg;
  wire logic gieNext = take ? 1'b0
                     : (returnFromIrqInstr ? 1'b1 : enBase[`PPI_BIT_GLOBAL]);
  wire logic [7:0] irqEnable_next = {gieNext, enBase[6:0]};

  // read data: flags read as flags AND enables
  wire logic [7:0] rdNext = selOd ? openDrain_reg
                          : selPh ? pullHighN_reg
                          : selEn ? irqEnable_reg
                          : selFl ? (irqFlags_reg & irqEnable_reg)
                          : 8'h00;

  // pin drive
  wire logic [7:0] outA     = ~dirA_reg;
  wire logic [7:0] outB     = ~dirB_reg;
  wire logic [7:0] oeANext  = outA & 8'hDF;
  wire logic [7:0] odActive = openDrain_reg & outB;
  wire logic [7:0] oeBNext  = outB & ~(odActive & portBLatch);
  wire logic [7:0] outBNext = portBLatch & ~odActive;
  wire logic [7:0] phNext   = ~pullHighN_reg & dirB_reg;
  wire logic [3:0] pdANext  = ~pullDownCtrlN[3:0] & dirA_reg[3:0];
  wire logic [3:0] pdBNext  = ~pullDownCtrlN[7:4] & dirB_reg[3:0];

  // pin synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA1_reg  <= 8'h00;
      syncA2_reg  <= 8'h00;
      syncA3_reg  <= 8'h00;
      syncB1_reg  <= 8'h00;
      syncB2_reg  <= 8'h00;
      syncB3_reg  <= 8'h00;
      stableA_reg <= 8'h00;
      stableB_reg <= 8'h00;
    end else begin
      syncA1_reg  <= portAPinIn;
      syncA2_reg  <= syncA1_reg;
      syncA3_reg  <= syncA2_reg;
      syncB1_reg  <= portBPinIn;
      syncB2_reg  <= syncB1_reg;
      syncB3_reg  <= syncB2_reg;
      stableA_reg <= stableA_next;
      stableB_reg <= stableB_next;
    end
  end

  // change reference and edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      portBRef_reg <= 8'h00;
      extLevel_reg <= 1'b0;
    end else begin
      if (portBAccess) portBRef_reg <= stableB_reg;
      extLevel_reg <= stableB_reg[0];
    end
  end

  // file registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      openDrain_reg <= `PPI_RST_OPEN_DRAIN;
      pullHighN_reg <= `PPI_RST_PULL_HIGH;
      irqEnable_reg <= `PPI_RST_IRQ_ENABLE;
      irqFlags_reg  <= `PPI_RST_IRQ_FLAGS;
    end else begin
      if (wrOd) openDrain_reg <= fileWrData;
      if (wrPh) pullHighN_reg <= fileWrData;
      irqEnable_reg <= irqEnable_next;
      irqFlags_reg  <= irqFlags_next;
    end
  end

  // write-only config and direction registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg  <= `PPI_RST_CONFIG;
      dirA_reg <= `PPI_RST_DIRECTION;
      dirB_reg <= `PPI_RST_DIRECTION;
    end else begin
      if (configInstr) cfg_reg <= workAccumulator[6:0];
      if (ldDirA) dirA_reg <= workAccumulator;
      if (ldDirB) dirB_reg <= workAccumulator;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fileRdData      <= 8'h00;
      portADrive      <= '0;
      portBDrive      <= '0;
      portBPullHighEn <= 8'h00;
      portAPullDownEn <= 4'h0;
      portBPullDownEn <= 4'h0;
      portAPinSync    <= 8'h00;
      portBPinSync    <= 8'h00;
      timerCfg        <= `PPI_RST_CONFIG;
      prescaleExp     <= 4'h0;
      irqVector       <= 1'b0;
      wakeResume      <= 1'b0;
    end else begin
      fileRdData      <= rdNext;
      portADrive      <= '{out: portALatch, oe: oeANext};
      portBDrive      <= '{out: outBNext, oe: oeBNext};
      portBPullHighEn <= phNext;
      portAPullDownEn <= pdANext;
      portBPullDownEn <= pdBNext;
      portAPinSync    <= stableA_reg;
      portBPinSync    <= stableB_reg;
      timerCfg        <= cfg_reg;
      prescaleExp     <= divExp(cfg_reg.prescalerAssign, cfg_reg.prescalerRatio);
      irqVector       <= take;
      wakeResume      <= sleepActive & pending & ~global_irq_enable;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  gie_clear_take_a: assert property (take |=> !global_irq_enable ##0 irqVector)
    else $error("global enable not cleared on taken interrupt");
  gie_set_ret_a: assert property (returnFromIrqInstr && !take |=> global_irq_enable)
    else $error("return did not set global enable");
  timer_flag_a: assert property (timerOverflow |=> irqFlags_reg[0])
    else $error("timer flag not set");
  flag_upper_zero_a: assert property (irqFlags_reg[7:3] == 5'h00 && irqEnable_reg[6:3] == 4'h0)
    else $error("unused bits not zero");
  pin5_no_drive_a: assert property (##1 !portADrive.oe[5])
    else $error("port A pin 5 driven");
  od_high_release_a: assert property (odActive[1] && portBLatch[1] |=> !portBDrive.oe[1])
    else $error("open-drain high not released");
  pull_high_out_a: assert property (!dirB_reg[2] |=> !portBPullHighEn[2])
    else $error("pull-high on output pin");
  pull_down_out_a: assert property (!dirA_reg[0] |=> !portAPullDownEn[0])
    else $error("pull-down on output pin");
  cfg_load_a: assert property (configInstr |=> cfg_reg == $past(workAccumulator[6:0]))
    else $error("config not loaded");
  dir_load_a: assert property (ldDirB |=> dirB_reg == $past(workAccumulator))
    else $error("direction B not loaded");
  pin0_masked_a: assert property (extIrqPinSelect |-> !changeMask[0])
    else $error("pin 0 change not masked");
  wake_resume_a: assert property (sleepActive && pending && !global_irq_enable |=> wakeResume && !irqVector)
    else $error("wake without vector missed");
  ext_flag_a: assert property (extEdge |=> irqFlags_reg[2])
    else $error("external edge flag missed");

  // pin drive and pull control
  od_low_drive_a: assert property (odActive[1] && !portBLatch[1] |=>
    portBDrive.oe[1] && !portBDrive.out[1])
    else $error("open-drain low not driven");
  od_input_off_a: assert property (dirB_reg[3] |=> !portBDrive.oe[3])
    else $error("input pin driven");
  dir_out_drive_a: assert property (!dirA_reg[0] |=>
    portADrive.oe[0] && portADrive.out[0] == $past(portALatch[0]))
    else $error("output pin not driving latch");
  pull_high_en_a: assert property (!pullHighN_reg[5] && dirB_reg[5] |=> portBPullHighEn[5])
    else $error("pull-high not enabled");
  pull_high_b_off_a: assert property (pullHighN_reg[6] |=> !portBPullHighEn[6])
    else $error("pull-high not disabled");
  pull_down_en_a: assert property (!pullDownCtrlN[4] && dirB_reg[0] |=> portBPullDownEn[0])
    else $error("port B pull-down not enabled");
  pd_a_en_a: assert property (!pullDownCtrlN[2] && dirA_reg[2] |=> portAPullDownEn[2])
    else $error("port A pull-down not enabled");
  pull_down_b_out_a: assert property (!dirB_reg[1] |=> !portBPullDownEn[1])
    else $error("port B pull-down on output pin");

  // write-only registers
  dir_a_load_a: assert property (ldDirA |=> dirA_reg == $past(workAccumulator))
    else $error("direction A not loaded");
  dir_a_hold_a: assert property (!ldDirA |=> dirA_reg == $past(dirA_reg))
    else $error("direction A changed without load");
  timer_cfg_copy_a: assert property (1'b1 |=> timerCfg == $past(cfg_reg))
    else $error("timer config copy wrong");
  prescale_exp_a: assert property (cfg_reg.prescalerAssign |=>
    prescaleExp == {1'b0, $past(cfg_reg.prescalerRatio)})
    else $error("watchdog ratio wrong");

  // file register access
  enable_write_a: assert property (wrEn && !take && !returnFromIrqInstr |=>
    irqEnable_reg == ($past(fileWrData) & `PPI_MASK_IRQ_ENABLE))
    else $error("enable write wrong");
  od_reg_write_a: assert property (wrOd |=> openDrain_reg == $past(fileWrData))
    else $error("open-drain write lost");
  ph_reg_write_a: assert property (wrPh |=> pullHighN_reg == $past(fileWrData))
    else $error("pull-high write lost");
  flag_clear_a: assert property (wrFl && !fileWrData[0] && !timerOverflow |=>
    !irqFlags_reg[0])
    else $error("flag clear lost");
  read_flags_a: assert property (selFl |=>
    fileRdData == ($past(irqFlags_reg) & $past(irqEnable_reg)))
    else $error("flag read wrong");
  rd_unmapped_a: assert property (!(selOd || selPh || selEn || selFl) |=>
    fileRdData == 8'h00)
    else $error("unmapped read not zero");

  // change, edge and vector
  sync_agree_a: assert property (syncB2_reg == syncB3_reg |=>
    stableB_reg == $past(syncB2_reg))
    else $error("agreed pin level not taken");
  change_flag_a: assert property (portChange && irqEnable_reg[1] |=> irqFlags_reg[1])
    else $error("port change flag missed");
  ext_mask_a: assert property (!extIrqPinSelect |-> !extEdge)
    else $error("external edge while pin is plain");
  ext_fall_a: assert property (extIrqPinSelect && !cfg_reg.extIrqEdgeSel
    && extLevel_reg && !stableB_reg[0] |-> extEdge)
    else $error("falling edge missed");
  wake_none_gie_a: assert property (global_irq_enable |=> !wakeResume)
    else $error("resume with global enable set");
  vector_needs_gie_a: assert property (irqVector |-> $past(global_irq_enable))
    else $error("vector without global enable");

  take_c: cover property (take ##1 returnFromIrqInstr);
  change_c: cover property (portChange ##1 irqFlags_reg[1]);
  ext_c: cover property (extEdge ##[1:4] irqVector);
  wake_c: cover property (wakeResume);
  od_c: cover property (odActive[7] && !portBLatch[7]);

endmodule // ppi_port_irq_ctrl

`default_nettype wire
